// ### logic/hfs_top.sv
/*
 Hammer fire sequencer: data and set registers, driver matrix, pulses.
 Assumes processor strobes and bus are asynchronous pins; static straps.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hfs_cfg.svh"

module hfs_top #(
	parameter int SPACING_SLOW = `HFS_SPACING_SLOW_NS / `HFS_CLK_NS,
	parameter int SPACING_FAST = `HFS_SPACING_FAST_NS / `HFS_CLK_NS
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// Processor card
	input  wire hfs_pkg::hfs_byte_t i_processor_output_bus,
	input  wire logic             i_odd_bank_data_strobe_n,
	input  wire logic             i_even_bank_data_strobe_n,
	input  wire logic             i_odd_set_reg_load_n,
	input  wire logic             i_even_set_reg_load_n,
	input  wire logic             i_system_clear,
	input  wire logic             i_hammer_preset_n,
	// Straps
	input  wire logic             i_two_bank,
	input  wire logic             i_fast_speed,
	// Hammer driver side
	output logic [8:0]            o_hammer_trigger_set_pulse_n,
	output logic                  o_clear_pulse_n,
	output hfs_pkg::hfs_byte_t    o_drive_a,
	output hfs_pkg::hfs_byte_t    o_drive_b,
	output logic                  o_odd_even_fire_trigger_n,
	output logic                  o_fire_bank,
	// Status
	output hfs_pkg::hfs_phase_t   o_phase,
	output logic [3:0]            o_subscan,
	output logic                  o_scan_even
);
	import hfs_pkg::*;

	localparam int PW    = `HFS_CYC_UP(`HFS_SET_PW_NS);
	localparam int SETUP = `HFS_CYC_UP(`HFS_SETUP_NS);
	localparam int HOLD  = `HFS_CYC_UP(`HFS_HOLD_NS);

	// ----------------------------------------------------------------
	// 4-to-10 decode: 1..9 pick S1..S9, others fire nothing
	// ----------------------------------------------------------------
	function automatic logic [4:0] hfs_decode(input logic [3:0] v);
		logic [4:0] r;
		r = 5'h00;
		if (v >= 4'h1 && v <= 4'h9) begin
			r = {1'b1, v - 4'h1};
		end
		return r;
	endfunction

	hfs_top_st_t st;
	hfs_top_st_t next_st;
	hfs_phase_t  g_phase;
	logic        g_set;
	logic        g_set_start;
	logic        g_clr;
	logic        g_clr_start;
	logic        g_lock;
	logic        g_wrap;
	logic [3:0]  strb_n;
	logic [3:0]  strb_rise;
	logic        sys_clr;
	logic        two_bank;
	logic [1:0]  fire;
	logic [4:0]  dec_a;
	logic [4:0]  dec_b;

	// ----------------------------------------------------------------
	// Timing generator
	// ----------------------------------------------------------------
	hfs_phase_gen #(
		.SPACING_SLOW (SPACING_SLOW),
		.SPACING_FAST (SPACING_FAST),
		.PW           (PW),
		.SETUP        (SETUP),
		.HOLD         (HOLD)
	) u_gen (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_fast      (st.ctl2[`HFS_CTL_FAST]),
		.o_phase     (g_phase),
		.o_set       (g_set),
		.o_set_start (g_set_start),
		.o_clr       (g_clr),
		.o_clr_start (g_clr_start),
		.o_lock      (g_lock),
		.o_wrap      (g_wrap)
	);

	// Synchronised control views, second stage only
	assign strb_n    = st.ctl2[3:0];
	assign strb_rise = strb_n & ~st.strb_prev;
	assign sys_clr   = st.ctl2[`HFS_CTL_SYS_CLEAR];
	assign two_bank  = st.ctl2[`HFS_CTL_TWO_BANK];
	assign dec_a     = hfs_decode(st.sel[0]);
	assign dec_b     = hfs_decode(st.sel[1]);

	// A bank fires when its decoded phase meets the set pulse
	always_comb begin
		fire = 2'b00;
		if (g_set_start && st.ctl2[`HFS_CTL_PRESET_N] && !sys_clr) begin
			fire[0] = dec_a[4] && (dec_a[3:0] == g_phase);
			fire[1] = two_bank && dec_b[4] && (dec_b[3:0] == g_phase);
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.bus1 = i_processor_output_bus;
		next_st.bus2 = st.bus1;
		next_st.ctl1 = {i_fast_speed, i_two_bank, i_hammer_preset_n, i_system_clear,
		                i_even_set_reg_load_n, i_odd_set_reg_load_n,
		                i_even_bank_data_strobe_n, i_odd_bank_data_strobe_n};
		next_st.ctl2 = st.ctl1;
		next_st.strb_prev = strb_n;
		for (int b = 0; b < 2; b++) begin
			// Held changes wait until the guard window closes
			if (st.pend_vld[b] && !g_lock) begin
				next_st.data[b] = st.pend[b];
				next_st.pend_vld[b] = 1'b0;
			end
			// A new strobe wins over the apply in the same cycle
			if (strb_rise[b]) begin
				next_st.pend[b] = st.bus2;
				next_st.pend_vld[b] = 1'b1;
			end
			if (strb_rise[b + 2]) begin
				next_st.sel[b] = st.bus2[`HFS_SETREG_MSB:0];
			end
			// Second clear leading edge after a set turns off
			if (g_clr_start && st.armed[b]) begin
				if (st.clr_seen[b]) begin
					next_st.drv[b] = 8'h00;
					next_st.armed[b] = 1'b0;
					next_st.clr_seen[b] = 1'b0;
				end else begin
					next_st.clr_seen[b] = 1'b1;
				end
			end
			if (fire[b]) begin
				next_st.drv[b] = st.data[b];
				next_st.armed[b] = 1'b1;
				next_st.clr_seen[b] = 1'b0;
			end
		end
		// Pulse outputs
		next_st.trig_n = '1;
		if (g_set) begin
			next_st.trig_n[g_phase] = 1'b0;
		end
		next_st.clear_n = !g_clr;
		next_st.fire_trig_n = !(|fire);
		next_st.fire_bank = !fire[0] && fire[1];
		next_st.phase = g_phase;
		// Subscan ring, and odd-then-even in single-bank mode
		if (g_wrap) begin
			if (st.subscan == 4'(`HFS_SUBSCANS - 1)) begin
				next_st.subscan = 4'h0;
				next_st.scan_even = two_bank ? 1'b0 : !st.scan_even;
			end else begin
				next_st.subscan = st.subscan + 4'h1;
			end
		end
		// System clear empties registers and matrix
		if (sys_clr) begin
			next_st.pend = '0;
			next_st.pend_vld = 2'b00;
			next_st.data = '0;
			next_st.sel = '0;
			next_st.drv = '0;
			next_st.armed = 2'b00;
			next_st.clr_seen = 2'b00;
		end
	end

	// State register; strobes idle high out of reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '{ctl1: 8'h2f, ctl2: 8'h2f, strb_prev: 4'hf, trig_n: 9'h1ff,
			        clear_n: 1'b1, fire_trig_n: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state
	assign o_hammer_trigger_set_pulse_n = st.trig_n;
	assign o_clear_pulse_n              = st.clear_n;
	assign o_drive_a                    = st.drv[0];
	assign o_drive_b                    = st.drv[1];
	assign o_odd_even_fire_trigger_n    = st.fire_trig_n;
	assign o_fire_bank                  = st.fire_bank;
	assign o_phase                      = st.phase;
	assign o_subscan                    = st.subscan;
	assign o_scan_even                  = st.scan_even;

	// ----------------------------------------------------------------
	// Checks; helper counters time pulse width and spacing
	// ----------------------------------------------------------------
	logic [15:0] low_cnt;
	logic [15:0] gap_cnt;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			low_cnt <= 16'h0000;
			gap_cnt <= 16'h0000;
		end else begin
			low_cnt <= (&st.trig_n) ? 16'h0000 : low_cnt + 16'h0001;
			gap_cnt <= ($fell(&st.trig_n)) ? 16'h0001 : gap_cnt + 16'h0001;
		end
	end

	sequence s_set_rises;
		$rose(|st.drv[0]);
	endsequence
	sequence s_trig_low;
		st.trig_n != 9'h1ff;
	endsequence

	property p_fire_coinc;
		@(posedge i_clk) disable iff (!i_rst_n) s_set_rises |-> s_trig_low;
	endproperty
	a_fire_coinc: assert property (p_fire_coinc) else $error("fire without set pulse");

	property p_pulse_width;
		@(posedge i_clk) disable iff (!i_rst_n) $rose(&st.trig_n) |-> low_cnt == 16'(PW);
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("set pulse width wrong");

	property p_spacing;
		@(posedge i_clk) disable iff (!i_rst_n)
			($fell(&st.trig_n) && gap_cnt > 16'(PW)) |->
			(gap_cnt == (st.ctl2[`HFS_CTL_FAST] ? 16'(SPACING_FAST) : 16'(SPACING_SLOW)));
	endproperty
	a_spacing: assert property (p_spacing) else $error("phase spacing wrong");

	property p_phase_ring;
		@(posedge i_clk) disable iff (!i_rst_n)
			(st.phase != $past(st.phase)) |->
			(st.phase == (($past(st.phase) == 4'h8) ? 4'h0 : $past(st.phase) + 4'h1));
	endproperty
	a_phase_ring: assert property (p_phase_ring) else $error("phase order broken");

	property p_data_hold;
		@(posedge i_clk) disable iff (!i_rst_n) (g_lock && !sys_clr) |=> $stable(st.data);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data moved in guard");

	property p_clear_edge;
		@(posedge i_clk) disable iff (!i_rst_n)
			(st.drv[0] == 8'h00 && $past(st.drv[0]) != 8'h00) |->
			($past(g_clr_start) || $past(sys_clr));
	endproperty
	a_clear_edge: assert property (p_clear_edge) else $error("driver off off-edge");

	property p_sys_clear;
		@(posedge i_clk) disable iff (!i_rst_n)
			sys_clr |=> (st.data == '0 && st.drv == '0 && st.sel == '0);
	endproperty
	a_sys_clear: assert property (p_sys_clear) else $error("system clear incomplete");

	property p_subscan;
		@(posedge i_clk) disable iff (!i_rst_n)
			g_wrap |=> st.subscan == (($past(st.subscan) == 4'h8) ? 4'h0 : $past(st.subscan) + 4'h1);
	endproperty
	a_subscan: assert property (p_subscan) else $error("subscan step wrong");

	property p_capture;
		@(posedge i_clk) disable iff (!i_rst_n)
			(strb_rise[0] && !sys_clr) |=> (st.pend_vld[0] && st.pend[0] == $past(st.bus2));
	endproperty
	a_capture: assert property (p_capture) else $error("strobe not captured");
endmodule // hfs_top

`default_nettype wire

// ### logic/hfs_cfg.svh
/*
 Timing and field constants of the hammer fire sequencer.
 Assumes a 200 MHz clock; included by bare name from the package and modules.
*/
`ifndef HFS_CFG_SVH
`define HFS_CFG_SVH

// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define HFS_CLK_NS          5
`define HFS_CYC_UP(ns)      (((ns) + `HFS_CLK_NS - 1) / `HFS_CLK_NS)
`define HFS_SET_PW_NS       1000
`define HFS_SETUP_NS        1000
`define HFS_HOLD_NS         1000
`define HFS_SPACING_SLOW_NS 151000
`define HFS_SPACING_FAST_NS 136000
`define HFS_PHASES          9
`define HFS_SUBSCANS        9

// ----------------------------------------------------------------
// Control pin positions in the synchroniser vector
// ----------------------------------------------------------------
`define HFS_CTL_ODD_DATA    0
`define HFS_CTL_EVEN_DATA   1
`define HFS_CTL_ODD_SET     2
`define HFS_CTL_EVEN_SET    3
`define HFS_CTL_SYS_CLEAR   4
`define HFS_CTL_PRESET_N    5
`define HFS_CTL_TWO_BANK    6
`define HFS_CTL_FAST        7
`define HFS_SETREG_MSB      3

`endif

// ### logic/hfs_pkg.sv
/*
 Types shared by the hammer fire sequencer modules.
 Assumes hfs_cfg.svh is on the include path.
*/
`default_nettype none
`include "hfs_cfg.svh"

package hfs_pkg;
	typedef logic [3:0]      hfs_phase_t;
	typedef logic [7:0]      hfs_byte_t;
	typedef logic [1:0][7:0] hfs_bank_bytes_t;

	// ----------------------------------------------------------------
	// Timing generator state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] cnt;
		hfs_phase_t  phase;
	} hfs_gen_st_t;

	// ----------------------------------------------------------------
	// Top state; index 0 is bank A, index 1 is bank B
	// ----------------------------------------------------------------
	typedef struct packed {
		hfs_byte_t       bus1;
		hfs_byte_t       bus2;
		logic [7:0]      ctl1;
		logic [7:0]      ctl2;
		logic [3:0]      strb_prev;
		hfs_bank_bytes_t pend;
		logic [1:0]      pend_vld;
		hfs_bank_bytes_t data;
		logic [1:0][3:0] sel;
		hfs_bank_bytes_t drv;
		logic [1:0]      armed;
		logic [1:0]      clr_seen;
		logic [8:0]      trig_n;
		logic            clear_n;
		logic            fire_trig_n;
		logic            fire_bank;
		hfs_phase_t      phase;
		logic [3:0]      subscan;
		logic            scan_even;
	} hfs_top_st_t;
endpackage

`default_nettype wire

// ### logic/hfs_phase_gen.sv
/*
 Nine-phase set and clear pulse timing generator.
 Assumes a static speed select already synchronised by the caller.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hfs_cfg.svh"

module hfs_phase_gen #(
	parameter int SPACING_SLOW = 30200,
	parameter int SPACING_FAST = 27200,
	parameter int PW           = 200,
	parameter int SETUP        = 200,
	parameter int HOLD         = 200
) (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	// Configuration
	input  wire logic          i_fast,
	// Timing
	output hfs_pkg::hfs_phase_t o_phase,
	output logic               o_set,
	output logic               o_set_start,
	output logic               o_clr,
	output logic               o_clr_start,
	output logic               o_lock,
	output logic               o_wrap
);
	import hfs_pkg::*;

	localparam logic [15:0] L_SLOW = 16'(SPACING_SLOW);
	localparam logic [15:0] L_FAST = 16'(SPACING_FAST);
	localparam logic [15:0] L_PW   = 16'(PW);
	localparam logic [15:0] L_HOLD = 16'(PW + HOLD);
	localparam logic [15:0] L_SU   = 16'(SETUP);

	// ----------------------------------------------------------------
	// Refuse spacings that leave no room for the guard windows
	// ----------------------------------------------------------------
	if (SPACING_FAST < 4 * (PW + SETUP + HOLD) || SPACING_SLOW > 65535 ||
	    SPACING_FAST > SPACING_SLOW || PW < 1) begin : g_bad
		$error("hfs_phase_gen: spacing too short or too long for counter");
	end

	hfs_gen_st_t st;
	hfs_gen_st_t next_st;
	logic [15:0] spacing;
	logic [15:0] half;

	// Spacing follows the speed strap; period is nine spacings
	assign spacing = i_fast ? L_FAST : L_SLOW;
	assign half    = {1'b0, spacing[15:1]};

	// Free-running spacing counter and phase ring
	always_comb begin
		next_st = st;
		if (st.cnt >= spacing - 16'h0001) begin
			next_st.cnt = 16'h0000;
			next_st.phase = (st.phase == 4'h8) ? 4'h0 : st.phase + 4'h1;
		end else begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end

	// Restart at phase one out of reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Set pulse leads the spacing, clear pulse sits mid-way
	assign o_phase     = st.phase;
	assign o_set       = st.cnt < L_PW;
	assign o_set_start = st.cnt == 16'h0000;
	assign o_clr       = (st.cnt >= half) && (st.cnt < half + L_PW);
	assign o_clr_start = st.cnt == half;
	// Data must not move inside this window
	assign o_lock      = (st.cnt < L_HOLD) || (st.cnt >= spacing - L_SU);
	assign o_wrap      = (st.phase == 4'h8) && (st.cnt >= spacing - 16'h0001);
endmodule // hfs_phase_gen

`default_nettype wire

// ### tb/hfs_proc_model.sv
/*
 Processor card model: puts compare data and set codes on the bus.
 Assumes the bench calls load at a falling clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module hfs_proc_model (
	// Clock
	input  wire logic               i_clk,
	// Processor pins
	output var hfs_pkg::hfs_byte_t  o_bus,
	output var logic [3:0]          o_strobe_n
);
	import hfs_pkg::*;

	// ------------------------------------
	// Idle state
	// ------------------------------------
	initial begin
		o_bus      = 8'h00;
		o_strobe_n = 4'hf;
	end

	// ------------------------------------
	// One load
	// ------------------------------------
	// Kind 0 odd data, 1 even data, 2 odd set code, 3 even set code
	task automatic load(input int kind, input hfs_byte_t val);
		o_bus = val;
		repeat (4) @(negedge i_clk);
		o_strobe_n[kind] = 1'b0;
		repeat (4) @(negedge i_clk);
		o_strobe_n[kind] = 1'b1;      // Rising edge loads
		repeat (4) @(negedge i_clk);  // Hold past the sync delay
		o_bus = ~val;                 // Released bus shows no stale value
		@(negedge i_clk);
	endtask
endmodule // hfs_proc_model

`default_nettype wire

// ### tb/testbench.sv
/*
 Self-checking bench of the hammer fire sequencer top.
 Assumes short spacing parameters and the processor card model.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import hfs_pkg::*;

	localparam int SLOW = 2600;
	localparam int FAST = 2400;
	localparam int PW   = 200;

	// ------------------------------------
	// Signals
	// ------------------------------------
	logic       i_clk     = 1'b0;
	logic       i_rst_n   = 1'b0;
	logic       sys_clear = 1'b0;
	logic       preset_n  = 1'b1;
	logic       two_bank  = 1'b1;
	logic       fast      = 1'b0;
	hfs_byte_t  bus;
	logic [3:0] strobe_n;
	logic [8:0] trig_n;
	logic       clear_n;
	logic       fire_n;
	logic       fire_bank;
	logic       scan_even;
	hfs_byte_t  drive_a;
	hfs_byte_t  drive_b;
	hfs_phase_t phase;
	logic [3:0] subscan;
	int         fail_count = 0;
	int         cmp_count  = 0;
	int         cyc        = 0;
	int         t_s1       = 0;

	// Clock and cycle count
	always #2.5 i_clk = ~i_clk;
	always @(posedge i_clk) cyc <= cyc + 1;

	hfs_proc_model hfs_proc_model_inst (
		.i_clk      (i_clk),
		.o_bus      (bus),
		.o_strobe_n (strobe_n)
	);

	hfs_top #(.SPACING_SLOW(SLOW), .SPACING_FAST(FAST)) hfs_top_inst (
		.i_clk                        (i_clk),
		.i_rst_n                      (i_rst_n),
		.i_processor_output_bus       (bus),
		.i_odd_bank_data_strobe_n     (strobe_n[0]),
		.i_even_bank_data_strobe_n    (strobe_n[1]),
		.i_odd_set_reg_load_n         (strobe_n[2]),
		.i_even_set_reg_load_n        (strobe_n[3]),
		.i_system_clear               (sys_clear),
		.i_hammer_preset_n            (preset_n),
		.i_two_bank                   (two_bank),
		.i_fast_speed                 (fast),
		.o_hammer_trigger_set_pulse_n (trig_n),
		.o_clear_pulse_n              (clear_n),
		.o_drive_a                    (drive_a),
		.o_drive_b                    (drive_b),
		.o_odd_even_fire_trigger_n    (fire_n),
		.o_fire_bank                  (fire_bank),
		.o_phase                      (phase),
		.o_subscan                    (subscan),
		.o_scan_even                  (scan_even)
	);

	// ------------------------------------
	// Common tasks
	// ------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("Compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Falling edge of set pulse p, or of the clear pulse when p is 9
	task automatic wait_fall(input int p);
		logic prev;
		logic now_v;
		int   n;
		prev = 1'b0;
		for (n = 0; n < 30000; n++) begin
			@(negedge i_clk);
			now_v = (p == 9) ? clear_n : trig_n[p];
			if (prev === 1'b1 && now_v === 1'b0) begin
				return;
			end
			prev = now_v;
		end
		fail_count++;
		results();
	endtask

	// Straps only change under reset, as they are static
	task automatic do_reset(input logic f, input logic two);
		@(negedge i_clk);
		i_rst_n  = 1'b0;
		preset_n = 1'b1;
		fast     = f;
		two_bank = two;
		repeat (5) @(negedge i_clk);
		check({drive_a, drive_b}, 16'h0000);
		check({trig_n, fire_n}, 10'h3ff);
		check({phase, subscan, scan_even}, 0);
		i_rst_n = 1'b1;
		repeat (3) @(negedge i_clk);
	endtask

	// ------------------------------------
	// Scenarios
	// ------------------------------------
	// Width of S2, spacing S2 to S3, one phase low at a time
	task automatic t_timing(input int sp);
		int t0;
		int w;
		wait_fall(1);
		t0 = cyc;
		w  = 0;
		while (trig_n[1] === 1'b0 && w < 1000) begin
			@(negedge i_clk);
			w++;
		end
		check(w, PW);
		check(phase, 1);
		wait_fall(2);
		check(cyc - t0, sp);
		check(trig_n, 9'h1fb);
	endtask

	// Bank A on S1, bank B on S5, driver off at second clear
	task automatic t_subscan1();
		hfs_proc_model_inst.load(0, 8'ha5);
		hfs_proc_model_inst.load(2, 8'h01);
		hfs_proc_model_inst.load(1, 8'h3c);
		hfs_proc_model_inst.load(3, 8'h05);
		wait_fall(0);
		t_s1 = cyc;
		check({fire_n, fire_bank}, 2'b00);
		check({drive_a, drive_b}, 16'ha500);
		wait_fall(9);
		repeat (PW + 2) @(negedge i_clk);
		check(drive_a, 8'ha5);
		wait_fall(9);
		repeat (2) @(negedge i_clk);
		check(drive_a, 8'h00);
		wait_fall(4);
		check({fire_n, fire_bank}, 2'b01);
		check({drive_a, drive_b}, 16'h003c);
	endtask

	// Bank B moves to S6; a late data load must not reach S1
	task automatic t_subscan2();
		hfs_proc_model_inst.load(1, 8'hc3);
		hfs_proc_model_inst.load(3, 8'h06);
		wait_fall(8);
		repeat (SLOW - 150) @(negedge i_clk);
		hfs_proc_model_inst.load(0, 8'h5a);
		wait_fall(0);
		check(cyc - t_s1, 9 * SLOW);
		check(drive_a, 8'ha5);
		check(subscan, 2);
		wait_fall(5);
		check({fire_n, fire_bank}, 2'b01);
		check(drive_b, 8'hc3);
	endtask

	// Clear empties the matrix; preset low blocks firing
	task automatic t_clear_preset();
		sys_clear = 1'b1;
		repeat (5) @(negedge i_clk);
		check({drive_a, drive_b}, 16'h0000);
		sys_clear = 1'b0;
		preset_n  = 1'b0;
		hfs_proc_model_inst.load(0, 8'hff);
		hfs_proc_model_inst.load(2, 8'h01);
		wait_fall(0);
		check({fire_n, drive_a}, 9'h100);
	endtask

	// Single bank: bank A fires, bank B stays idle
	task automatic t_single_bank();
		hfs_proc_model_inst.load(0, 8'h81);
		hfs_proc_model_inst.load(2, 8'h05);
		hfs_proc_model_inst.load(1, 8'hff);
		hfs_proc_model_inst.load(3, 8'h05);
		wait_fall(4);
		check({fire_n, fire_bank}, 2'b00);
		check({drive_a, drive_b}, 16'h8100);
		check(scan_even, 0);
	endtask

	// ------------------------------------
	// Main sequence
	// ------------------------------------
	initial begin
		do_reset(1'b0, 1'b1);
		t_timing(SLOW);
		t_subscan1();
		t_subscan2();
		t_clear_preset();
		do_reset(1'b1, 1'b0);
		t_timing(FAST);
		t_single_bank();
		results();
	end
endmodule // testbench

`default_nettype wire
